// [src/drpd_ctl.sv]
// DDR2 refresh, self-refresh and power-down controller, host side.
// Summary of operation
// R1: Refresh on average at least every 7.8125 us, all rows within 64 ms.
// R2: Above 85 C case temperature the refresh interval shrinks to 3.9 us.
// R3: Device refresh period runs from the registered REFRESH for the refresh cycle time.
// R4: Precharge all banks, A10 high, before a REFRESH when rows are open.
// R5: Self refresh only from all banks idle, REFRESH with clock enable falling.
// R6: Memory clock stays stable one clock after entry and before exit.
// R7: After self-refresh exit only NOP until the exit-to-non-read delay elapses.
// R8: No READ until 200 clocks after self-refresh exit.
// R9: Device leaves self refresh asynchronously; delays start at first qualified edge.
// R10: Clock enable stays high until read delay, except self-refresh re-entry.
// R11: Termination off before self refresh, held low until read delay after exit.
// R12: Every clock-enable level is registered on three consecutive rising edges.
// R13: Clock enable stays high from READ or WRITE until its burst completes.
// R14: Burst completion includes postamble plus write recovery or write-to-read time.
// R15: Power-down entered with clock enable low and NOP; mode follows open rows.
// R16: No power-down or self refresh while an access or precharge is busy.
// R17: Device disables buffers in power-down, freezes its loop in precharge mode.
// R18: Device leaves power-down when clock enable registers high with NOP.
// R19: Exit delay before non-read; fast or slow exit delay before READ.
// R20: An unlocked loop at power-down entry needs a loop reset after exit.
// R21: Clock frequency is unchanged across active power-down.
// R22: Termination control is driven to a valid level during power-down.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module drpd_ctl
  import drpd_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_bank_open,
  input  wire logic        i_access_busy,
  output logic             o_ck,
  output logic             o_ck_n,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic             o_a10,
  output logic             o_odt,
  output logic             o_grant_nonread,
  output logic             o_grant_read
);

  drpd_state_e      state_reg;
  logic [6:0]       ctrl_reg;
  logic [15:0]      refs_reg;
  logic [CNT_W-1:0] ref_cnt_reg;
  logic [CNT_W-1:0] nr_val_reg;
  logic [CNT_W-1:0] rd_val_reg;
  logic [3:0]       cmd_reg;
  logic [1:0]       cke_age_reg;
  logic             cke_last_reg;
  logic             ref_pend_reg;
  logic             ref_done_reg;
  logic             goal_sr_reg;
  logic             pd_act_reg;
  logic             dll_ent_reg;
  logic             dll_set_reg;
  logic             dll_need_reg;
  logic             nr_load_reg;
  logic             rd_load_reg;
  logic             step;
  logic             nr_zero;
  logic             rd_zero;
  logic             cke_ok;
  logic             ref_due;

  // ==========================================================================
  // Memory clock and wait timers
  // ==========================================================================
  drpd_clkdiv u_clkdiv (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .o_ck   (o_ck),
    .o_ck_n (o_ck_n),
    .o_step (step)
  );

  // Waits of the state sequence and the exit-to-non-read delay.
  drpd_timer #(.W(CNT_W)) u_nr_tmr (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_load  (nr_load_reg),
    .i_value (nr_val_reg),
    .i_step  (step),
    .o_zero  (nr_zero)
  );

  // The exit-to-read delay runs beside it, since both start at one exit.
  drpd_timer #(.W(CNT_W)) u_rd_tmr (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_load  (rd_load_reg),
    .i_value (rd_val_reg),
    .i_step  (step),
    .o_zero  (rd_zero)
  );

  // ==========================================================================
  // Clock-enable age
  // ==========================================================================
  // R12 hold three edges
  // The age counts rising edges seen since the last level change.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cke_last_reg <= 1'b1;
      cke_age_reg  <= 2'h3;
    end else if (step) begin
      cke_last_reg <= o_cke;
      if (o_cke != cke_last_reg) begin
        cke_age_reg <= 2'h1;
      end else if (cke_age_reg != 2'h3) begin
        cke_age_reg <= cke_age_reg + 2'h1;
      end
    end
  end

  assign cke_ok = (cke_age_reg == 2'h3) && (o_cke == cke_last_reg);

  // ==========================================================================
  // Refresh interval
  // ==========================================================================
  // R1 R2 interval count
  // A pending flag is raised each interval; a new one wins over its clear.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ref_cnt_reg  <= '0;
      ref_pend_reg <= 1'b0;
    end else begin
      if (step) begin
        if (state_reg == ST_SR || ref_due) begin
          ref_cnt_reg <= '0;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + 1'b1;
        end
      end
      if (step && ref_due && state_reg != ST_SR) begin
        ref_pend_reg <= 1'b1;
      end else if (ref_done_reg || state_reg == ST_SR) begin
        ref_pend_reg <= 1'b0;
      end
    end
  end

  assign ref_due = ctrl_reg[C_HOT] ? (ref_cnt_reg >= CNT_W'(TREFI_HOT_CK - 1))
                                   : (ref_cnt_reg >= CNT_W'(TREFI_CK - 1));

  // ==========================================================================
  // Power-state sequencer
  // ==========================================================================
  // Decisions are taken on the falling memory clock edge, so every command
  // and clock-enable level is settled half a period before it is registered.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_reg    <= ST_IDLE;
      cmd_reg      <= CMD_NOP;
      o_a10        <= 1'b0;
      o_cke        <= 1'b1;
      goal_sr_reg  <= 1'b0;
      pd_act_reg   <= 1'b0;
      dll_ent_reg  <= 1'b0;
      dll_set_reg  <= 1'b0;
      ref_done_reg <= 1'b0;
      nr_load_reg  <= 1'b0;
      rd_load_reg  <= 1'b0;
      nr_val_reg   <= '0;
      rd_val_reg   <= '0;
    end else begin
      nr_load_reg  <= 1'b0;
      rd_load_reg  <= 1'b0;
      dll_set_reg  <= 1'b0;
      ref_done_reg <= 1'b0;
      if (step) begin
        cmd_reg <= CMD_NOP;
        o_a10   <= 1'b0;
        case (state_reg)
          ST_IDLE: begin
            // R13 R14 R16 busy blocks entry
            if (!i_access_busy && nr_zero) begin
              if (ref_pend_reg && ctrl_reg[C_REF_EN]) begin
                goal_sr_reg <= 1'b0;
                nr_load_reg <= 1'b1;
                state_reg   <= ST_TRP;
                // R4 precharge all first
                if (i_bank_open) begin
                  cmd_reg    <= CMD_PRE;
                  o_a10      <= 1'b1;
                  nr_val_reg <= CNT_W'(TRP_CK);
                end else begin
                  nr_val_reg <= '0;
                end
              end else if (ctrl_reg[C_SR_REQ] && cke_ok) begin
                // R11 termination off first
                goal_sr_reg <= 1'b1;
                nr_load_reg <= 1'b1;
                nr_val_reg  <= CNT_W'(TAOF_CK);
                state_reg   <= ST_ODTOFF;
              end else if (ctrl_reg[C_PD_REQ] && cke_ok && rd_zero) begin
                // R10 R15 power-down entry
                o_cke       <= 1'b0;
                pd_act_reg  <= i_bank_open;
                dll_ent_reg <= ctrl_reg[C_DLL_UNL];
                state_reg   <= ST_PD;
              end
            end
          end
          ST_ODTOFF: begin
            if (nr_zero) begin
              nr_load_reg <= 1'b1;
              state_reg   <= ST_TRP;
              if (i_bank_open) begin
                cmd_reg    <= CMD_PRE;
                o_a10      <= 1'b1;
                nr_val_reg <= CNT_W'(TRP_CK);
              end else begin
                nr_val_reg <= '0;
              end
            end
          end
          ST_TRP: begin
            if (nr_zero) begin
              cmd_reg <= CMD_REF;
              if (goal_sr_reg) begin
                // R5 refresh with enable low
                o_cke     <= 1'b0;
                state_reg <= ST_SR;
              end else begin
                // R3 refresh cycle wait
                ref_done_reg <= 1'b1;
                nr_load_reg  <= 1'b1;
                nr_val_reg   <= CNT_W'(TRFC_CK);
                state_reg    <= ST_TRFC;
              end
            end
          end
          ST_TRFC: begin
            if (nr_zero) begin
              state_reg <= ST_IDLE;
            end
          end
          ST_SR: begin
            // R9 exit delays start
            if (cke_ok && !ctrl_reg[C_SR_REQ]) begin
              o_cke       <= 1'b1;
              nr_load_reg <= 1'b1;
              rd_load_reg <= 1'b1;
              nr_val_reg  <= CNT_W'(TXSNR_CK);
              rd_val_reg  <= CNT_W'(TXSRD_CK);
              state_reg   <= ST_SRX;
            end
          end
          ST_SRX: begin
            // R7 NOP until delay
            if (nr_zero) begin
              state_reg <= ST_IDLE;
            end
          end
          ST_PD: begin
            // R18 exit with NOP
            if (cke_ok && (!ctrl_reg[C_PD_REQ] || (ref_pend_reg && ctrl_reg[C_REF_EN]))) begin
              o_cke       <= 1'b1;
              dll_set_reg <= dll_ent_reg;
              nr_load_reg <= 1'b1;
              rd_load_reg <= 1'b1;
              nr_val_reg  <= CNT_W'(TXP_CK);
              // R19 fast or slow exit
              if (!pd_act_reg) begin
                rd_val_reg <= CNT_W'(TXP_CK);
              end else if (ctrl_reg[C_SLOW]) begin
                rd_val_reg <= CNT_W'(TXARDS_CK);
              end else begin
                rd_val_reg <= CNT_W'(TXARD_CK);
              end
              state_reg <= ST_PDX;
            end
          end
          ST_PDX: begin
            if (nr_zero) begin
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign o_cs_n  = cmd_reg[3];
  assign o_ras_n = cmd_reg[2];
  assign o_cas_n = cmd_reg[1];
  assign o_we_n  = cmd_reg[0];

  // ==========================================================================
  // Termination, loop-reset flag and grants
  // ==========================================================================
  // R11 R22 termination level
  // Termination is always driven, and is held low on the whole self-refresh
  // path and until the exit-to-read delay has run out.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_odt           <= 1'b0;
      o_grant_nonread <= 1'b0;
      o_grant_read    <= 1'b0;
    end else begin
      o_odt <= ctrl_reg[C_ODT_EN] && rd_zero && !goal_sr_reg &&
               state_reg inside {ST_IDLE, ST_TRP, ST_TRFC, ST_PD, ST_PDX};
      o_grant_nonread <= (state_reg == ST_IDLE) && nr_zero && o_cke;
      // R8 R20 read gate
      o_grant_read    <= (state_reg == ST_IDLE) && nr_zero && o_cke && rd_zero &&
                         !dll_need_reg;
    end
  end

  // R20 loop reset flag
  // A flag raised in the clearing cycle survives the clear.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      dll_need_reg <= 1'b0;
    end else if (dll_set_reg) begin
      dll_need_reg <= 1'b1;
    end else if (i_wr && i_addr == REG_CTRL && i_wdata[C_DLL_CLR]) begin
      dll_need_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Software registers
  // ==========================================================================
  // Control is written whole; the loop-reset clear bit is a write pulse.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ctrl_reg <= CTRL_RST;
      refs_reg <= 16'h0000;
    end else begin
      if (i_wr && i_addr == REG_CTRL) begin
        ctrl_reg <= i_wdata[6:0];
      end
      if (ref_done_reg) begin
        refs_reg <= refs_reg + 16'h0001;
      end
    end
  end

  // Read data stand one cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd && i_addr == REG_CTRL) begin
      o_rdata <= {9'h000, ctrl_reg};
    end else if (i_rd && i_addr == REG_STAT) begin
      o_rdata <= {7'h00, ref_pend_reg, dll_need_reg, o_grant_read, o_grant_nonread,
                  o_cke, 4'(state_reg)};
    end else if (i_rd && i_addr == REG_REFS) begin
      o_rdata <= refs_reg;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  property p_ref_interval;
    ref_cnt_reg < CNT_W'(TREFI_CK);
  endproperty
  a_ref_interval: assert property (p_ref_interval) // R1
    else $error("Refresh interval counter overran its limit.");

  property p_ref_hot;
    ctrl_reg[C_HOT] && $past(ctrl_reg[C_HOT]) && $past(ctrl_reg[C_HOT], 2) |->
      ref_cnt_reg < CNT_W'(TREFI_HOT_CK);
  endproperty
  a_ref_hot: assert property (p_ref_hot) // R2
    else $error("Hot refresh interval exceeded.");

  property p_pre_all;
    cmd_reg == CMD_PRE && $changed(cmd_reg) |-> o_a10;
  endproperty
  a_pre_all: assert property (p_pre_all) // R4
    else $error("Precharge issued without the all-bank bit.");

  property p_sr_entry;
    $fell(o_cke) && cmd_reg == CMD_REF |-> !o_odt && $past(state_reg) == ST_TRP;
  endproperty
  a_sr_entry: assert property (p_sr_entry) // R5
    else $error("Self refresh entered outside the idle path.");

  property p_cke_hold;
    $changed(o_cke) |=> $stable(o_cke)[*5];
  endproperty
  a_cke_hold: assert property (p_cke_hold) // R12
    else $error("Clock enable changed before three registrations.");

  property p_srx_nop;
    state_reg == ST_SRX |-> cmd_reg == CMD_NOP && !o_grant_read;
  endproperty
  a_srx_nop: assert property (p_srx_nop) // R7
    else $error("Command issued during self-refresh exit delay.");

  property p_busy_cke;
    $fell(o_cke) |-> !$past(i_access_busy);
  endproperty
  a_busy_cke: assert property (p_busy_cke) // R16
    else $error("Clock enable dropped while an access was busy.");

  property p_odt_exit;
    !rd_zero |=> !o_odt;
  endproperty
  a_odt_exit: assert property (p_odt_exit) // R11
    else $error("Termination raised before the read delay ran out.");

  property p_sr_read;
    $rose(o_cke) && state_reg == ST_SRX |-> !o_grant_read [*8];
  endproperty
  a_sr_read: assert property (p_sr_read) // R8
    else $error("Read granted too soon after self-refresh exit.");

endmodule // drpd_ctl
`default_nettype wire

// [src/drpd_pkg.sv]
// Constants, encodings and helpers for the DDR2 refresh and power-down controller.
package drpd_pkg;

  // ==========================================================================
  // Clocking
  // ==========================================================================
  localparam int unsigned MCLK_PS = 100000;          // System clock period.
  localparam int unsigned CK_DIV  = 2;               // System clocks per memory clock.
  localparam int unsigned CK_PS   = MCLK_PS * CK_DIV;

  // A longest time rounds down to whole memory clocks, never below one.
  function automatic int unsigned cyc_floor(input int unsigned ps);
    return (ps / CK_PS < 1) ? 1 : ps / CK_PS;
  endfunction

  // A least time rounds up to whole memory clocks, never below one.
  function automatic int unsigned cyc_ceil(input int unsigned ps);
    return ((ps + CK_PS - 1) / CK_PS < 1) ? 1 : (ps + CK_PS - 1) / CK_PS;
  endfunction

  // ==========================================================================
  // Timing, in picoseconds and in memory clocks
  // ==========================================================================
  localparam int unsigned TREFI_PS     = 7812500;
  localparam int unsigned TREFI_HOT_PS = 3900000;
  localparam int unsigned TRFC_PS      = 127500;      // Plain default.
  localparam int unsigned TRP_PS       = 15000;       // Plain default.
  localparam int unsigned TXSNR_PS     = TRFC_PS + 10000;
  localparam int unsigned TREFI_CK     = cyc_floor(TREFI_PS);
  localparam int unsigned TREFI_HOT_CK = cyc_floor(TREFI_HOT_PS);
  localparam int unsigned TRFC_CK      = cyc_ceil(TRFC_PS);
  localparam int unsigned TRP_CK       = cyc_ceil(TRP_PS);
  localparam int unsigned TXSNR_CK     = cyc_ceil(TXSNR_PS);
  localparam int unsigned TXSRD_CK     = 200;
  localparam int unsigned TCKE_CK      = 3;
  localparam int unsigned TXP_CK       = 2;           // Plain default.
  localparam int unsigned TXARD_CK     = 2;           // Plain default.
  localparam int unsigned TXARDS_CK    = 7;           // Plain default.
  localparam int unsigned TAOF_CK      = 3;           // Plain default.
  localparam int unsigned CNT_W        = 8;

  // ==========================================================================
  // Register map and fields
  // ==========================================================================
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STAT   = 4'h4;
  localparam logic [3:0]  REG_REFS   = 4'h8;
  localparam logic [6:0]  CTRL_RST   = 7'h01;
  localparam int unsigned C_REF_EN   = 0;
  localparam int unsigned C_HOT      = 1;
  localparam int unsigned C_SR_REQ   = 2;
  localparam int unsigned C_PD_REQ   = 3;
  localparam int unsigned C_SLOW     = 4;
  localparam int unsigned C_ODT_EN   = 5;
  localparam int unsigned C_DLL_UNL  = 6;
  localparam int unsigned C_DLL_CLR  = 7;

  // ==========================================================================
  // Commands as {cs_n, ras_n, cas_n, we_n}
  // ==========================================================================
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TRP, ST_TRFC, ST_ODTOFF, ST_SR, ST_SRX, ST_PD, ST_PDX
  } drpd_state_e;

endpackage : drpd_pkg

// [src/drpd_clkdiv.sv]
// Memory clock divider for the DDR2 refresh and power-down controller.
`timescale 1ns/100ps
`default_nettype none
module drpd_clkdiv (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  output logic      o_ck,
  output logic      o_ck_n,
  output logic      o_step
);

  // ==========================================================================
  // Divide by two
  // ==========================================================================
  // R6 R21 clock free running
  // The clock never stops, so it is stable around every power state change.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_ck   <= 1'b0;
      o_ck_n <= 1'b1;
    end else begin
      o_ck   <= ~o_ck;
      o_ck_n <= o_ck;
    end
  end

  // Commands change on the falling memory clock edge, half a period ahead.
  assign o_step = o_ck;

endmodule // drpd_clkdiv
`default_nettype wire

// [src/drpd_timer.sv]
// Loadable down counter stepped once per memory clock.
`timescale 1ns/100ps
`default_nettype none
module drpd_timer #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  input  wire logic         i_step,
  output logic              o_zero
);

  logic [W-1:0] cnt_reg;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // A load wins over a step so that a fresh wait is never shortened.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_value;
    end else if (i_step && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign o_zero = (cnt_reg == '0);

endmodule // drpd_timer
`default_nettype wire

// [tb/drpd_dev_model.sv]
// Behavioural DDR2 device that judges clock-enable and command use.
`timescale 1ns/100ps
`default_nettype none
module drpd_dev_model
  import drpd_pkg::*;
(
  input  wire logic       i_ck,
  input  wire logic       i_cke,
  input  wire logic [3:0] i_cmd,
  input  wire logic       i_odt,
  output logic      [1:0] o_mode,
  output logic            o_bad
);
  logic cke_q = 1'b1;
  int   run   = 0;
  int   quiet = 0;
  initial o_mode = 2'h0;
  initial o_bad = 1'b0;
  // ==========================================================================
  // Registration at each rising memory clock
  // ==========================================================================
  // Mode 0 is active, 1 power-down, 2 self refresh; o_bad is sticky.
  always @(posedge i_ck) begin
    run <= (i_cke == cke_q) ? run + 1 : 1;
    cke_q <= i_cke;
    if (quiet > 0) quiet <= quiet - 1;
    if (i_cke != cke_q && run < TCKE_CK) o_bad <= 1'b1;
    // only NOP while refresh or exit runs
    if (quiet > 0 && o_mode == 2'h0 && i_cmd != CMD_NOP) o_bad <= 1'b1;
    if (i_cke && i_cmd == CMD_REF) quiet <= TRFC_CK;
    if (cke_q && !i_cke) begin
      if (i_cmd == CMD_REF && !i_odt) o_mode <= 2'h2;
      else if (i_cmd == CMD_NOP) o_mode <= 2'h1;
      else o_bad <= 1'b1;
    end
    // exit with NOP, delays count from here
    if (!cke_q && i_cke) begin
      o_mode <= 2'h0;
      if (i_cmd != CMD_NOP) o_bad <= 1'b1;
      if (o_mode == 2'h2) quiet <= TXSNR_CK;
    end
  end
endmodule // drpd_dev_model
`default_nettype wire

// [tb/drpd_testbench.sv]
// Self-checking bench for the refresh and power-down controller.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import drpd_pkg::*;
;
  logic        i_mclk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_access_busy = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata;
  logic        o_ck, o_ck_n, o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_a10, o_odt;
  logic        o_grant_nonread, o_grant_read, bad, ref_q = 0, pre_a10 = 0;
  logic        opened = 0, hold = 0, held_bad = 0;
  logic [1:0]  mode;
  int          miscompares = 0, n_compared = 0, n, m, since = 0, gap = 0, nrefs = 0, tgt = 0;
  int          opens = 0, pre_seen = 0;
  // A row stays open from each opening until the next precharge-all is seen.
  wire         i_bank_open = opens != pre_seen;
  wire [3:0]   cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
  wire         is_ref = cmd == CMD_REF && o_cke;
  wire [4:0]   ev = {nrefs >= tgt, o_cke, !o_cke, o_grant_read, o_grant_nonread};
  drpd_ctl i_drpd_ctl (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_bank_open, .i_access_busy, .o_ck, .o_ck_n, .o_cke, .o_cs_n, .o_ras_n, .o_cas_n,
    .o_we_n, .o_a10, .o_odt, .o_grant_nonread, .o_grant_read);
  drpd_dev_model i_drpd_dev_model (.i_ck(o_ck), .i_cke(o_cke), .i_cmd(cmd), .i_odt(o_odt),
    .o_mode(mode), .o_bad(bad));
  // Free-running 10 MHz system clock.
  always #50 i_mclk = ~i_mclk;
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task ok(input logic c);
    chk({15'h0, c}, 16'h0001);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task rdc(input logic [3:0] a, input logic [15:0] msk, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & msk, e);
  endtask
  // Bounded wait on one event; running out ends the run.
  task waitev(input int k, output int c);
    c = 0;
    do begin
      @(posedge i_mclk);
      c++;
    end while (ev[k] !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      chk(16'h0001, 16'h0000);
      results();
    end
  endtask
  task gapchk(input int lim);
    tgt = nrefs + 2;
    waitev(4, n);
    ok(gap <= lim);
  endtask
  task results();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Pin monitor
  // ==========================================================================
  // Refresh spacing, precharge-all before refresh, and the exit hold window.
  always @(posedge i_mclk) begin
    ref_q <= is_ref;
    since <= since + 1;
    if (i_bank_open) opened <= 1'b1;
    if (cmd == CMD_PRE && o_a10) begin
      pre_a10 <= 1'b1;
      pre_seen <= opens;
    end
    if (is_ref && !ref_q) begin
      gap <= since;
      since <= 1;
      nrefs <= nrefs + 1;
      opened <= 1'b0;
      pre_a10 <= 1'b0;
      if (opened) ok(pre_a10);
    end
    if (hold && !o_grant_read && (o_odt || !o_cke)) held_bad <= 1'b1;
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rdc(REG_CTRL, 16'hffff, 16'h0001);
    rdc(REG_STAT, 16'h001f, 16'h0010);
    rdc(REG_REFS, 16'hffff, 16'h0000);
    wr(4'hc, 16'hffff);
    rdc(4'hc, 16'hffff, 16'h0000);
    rdc(REG_CTRL, 16'hffff, 16'h0001);
    $display("Test reset and map done");
    opens <= opens + 1;
    gapchk(TREFI_CK * CK_DIV);
    wr(REG_CTRL, 16'h0003);
    gapchk(TREFI_HOT_CK * CK_DIV);
    $display("Test refresh done");
    wr(REG_CTRL, 16'h0025);
    waitev(2, n);
    repeat (8) @(posedge i_mclk);
    chk({14'h0, mode}, 16'h0002);
    rdc(REG_STAT, 16'h001f, 16'h0004);
    wr(REG_CTRL, 16'h0021);
    waitev(3, n);
    hold <= 1'b1;
    waitev(0, n);
    ok(n >= TXSNR_CK * CK_DIV);
    waitev(1, m);
    hold <= 1'b0;
    ok(n + m >= TXSRD_CK * CK_DIV);
    chk({15'h0, held_bad}, 16'h0000);
    $display("Test self refresh done");
    i_access_busy <= 1'b1;
    wr(REG_CTRL, 16'h0018);
    repeat (40) @(posedge i_mclk);
    ok(o_cke);
    i_access_busy <= 1'b0;
    opens <= opens + 1;
    waitev(2, n);
    repeat (8) @(posedge i_mclk);
    chk({14'h0, mode}, 16'h0001);
    rdc(REG_STAT, 16'h001f, 16'h0006);
    wr(REG_CTRL, 16'h0010);
    waitev(3, n);
    waitev(0, n);
    ok(n >= TXP_CK * CK_DIV);
    waitev(1, m);
    ok(n + m >= TXARDS_CK * CK_DIV);
    // A second round enters with an unlocked loop, so reads wait for its reset.
    wr(REG_CTRL, 16'h0048);
    waitev(2, n);
    wr(REG_CTRL, 16'h0040);
    waitev(3, n);
    repeat (20) @(posedge i_mclk);
    rdc(REG_STAT, 16'h0080, 16'h0080);
    ok(!o_grant_read);
    wr(REG_CTRL, 16'h0080);
    rdc(REG_STAT, 16'h0080, 16'h0000);
    waitev(1, m);
    ok(o_grant_read);
    $display("Test power-down done");
    chk({15'h0, bad}, 16'h0000);
    results();
  end
endmodule // testbench
`default_nettype wire
